// ===== data_side_bus_request_master_tb_top.sv
/* Bench for dsrm_request_master with the slave model on its bus side.
   Assumes one 100 MHz clock; config set over classic Wishbone. */
`timescale 1ns/1ns
`default_nettype none
module data_side_bus_request_master_tb_top import dsrm_pkg::*;;
	logic        clock, rst_b, clk_en, core_reset, hold_ack, req_q;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, cfg;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        cmd_valid, cmd_read, cmd_cacheable, cmd_write_thru;
	logic        cmd_user_attr, cmd_guarded, cmd_touch, cmd_line_write;
	logic        cmd_hit, cmd_stall, cmd_rd_ready, cmd_wr_ready, cmd_taken;
	logic [0:31] cmd_addr, request_address;
	logic [2:0]  cmd_nbytes;
	logic        data_access_request, read_not_write, line_size_select;
	logic        cacheable_attr, write_through_attr, user_defined_attr;
	logic        guarded_attr, request_abort, slave_address_ack;
	logic        write_data_ack, write_data_last, read_complete;
	logic [0:7]  byte_lane_enables;
	logic [0:1]  request_priority;
	logic [47:0] exp_q[$];
	int          n_fail, n_compared, k;
	integer      seed = 32'h8DD6;
	dsrm_request_master i_dut (.*);
	dsrm_slave_model i_slave (.*);
	always #5 clock = ~clock;
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int t;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		wb_sel_i <= s;
		t = 0;
		do @(posedge clock); while (wb_ack_o !== 1'b1 && ++t < 50);
		if (t >= 50) begin
			n_fail++;
			$display("ERROR %0t wishbone ack timed out", $time);
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clock);
	endtask : wb
	// expectation noted before the command goes in
	task automatic run_cmd(input logic hit);
		logic [31:0] r, a;
		logic        rw, ca, tc, lw, al, ln, er;
		logic [3:0]  nb;
		int          o, n, t;
		r = $random(seed);
		a = $random(seed);
		rw = r[0] && !hit;
		ca = r[1] || hit;
		lw = r[6] && r[7] && !rw && !hit;
		tc = r[5] && rw && ca && !lw;
		o = a[1:0];
		n = r[11:9] == 3'h0 ? 1 : (r[11:9] > 3'h4 ? 4 : r[11:9]);
		n = n > 4 - o ? 4 - o : n;
		nb = 4'(((1 << n) - 1) << (4 - o - n));
		al = ca && (tc || !cfg[rw ? DSRM_CFG_LOAD_NO_ALLOCATE_BIT : DSRM_CFG_STORE_NO_ALLOCATE_BIT]);
		ln = lw || (rw && !ca ? cfg[DSRM_CFG_LWL_BIT] : al);
		er = !lw && (rw || al);
		{cmd_read, cmd_cacheable, cmd_write_thru, cmd_user_attr, cmd_guarded,
			cmd_touch, cmd_line_write, cmd_hit, cmd_stall} <=
			{rw, ca, r[2] && !hit, r[3], r[4], tc, lw, hit, r[8]};
		{cmd_addr, cmd_nbytes, cmd_valid} <= {a, r[11:9], 1'b1};
		if (!hit) exp_q.push_back({er, ln, ca, ca && r[2], r[3], r[4],
			cfg[DSRM_CFG_PRIO_BIT], er || r[8], ln ? 8'h00 : (a[2] ?
			{4'h0, nb} : {nb, 4'h0}), ln ? {a[31:5], 5'h00} : a});
		t = 0;
		do @(posedge clock); while (cmd_taken !== 1'b1 && ++t < 100);
		chk(t < 100, 1'b1);
		cmd_valid <= 1'b0;
		@(posedge clock);
	endtask : run_cmd
	// a write-back store hit must raise no request at all
	always @(posedge clock) begin
		if (data_access_request === 1'b1 && !req_q) begin
			if (exp_q.size() == 0) chk(1'b1, 1'b0);
			else chk({read_not_write, line_size_select, cacheable_attr,
				write_through_attr, user_defined_attr, guarded_attr,
				request_priority, byte_lane_enables, request_address},
				exp_q.pop_front());
		end
		req_q <= data_access_request === 1'b1;
	end
	initial begin
		{clock, rst_b, core_reset, hold_ack, req_q, clk_en} = 6'h1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
		{cmd_valid, cmd_read, cmd_cacheable, cmd_write_thru, cmd_user_attr,
			cmd_guarded, cmd_touch, cmd_line_write, cmd_hit} = '0;
		{cmd_stall, cmd_addr, cmd_nbytes, n_fail, n_compared} = '0;
		cfg = DSRM_CFG_RST;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		wb(1'b0, DSRM_CFG_OFS, 32'h0, 4'hF);
		chk(rd, 48'(DSRM_CFG_RST));
		wb(1'b1, 8'h0C, 32'hFFFFFFFF, 4'hF);
		wb(1'b0, 8'h0C, 32'h0, 4'hF);
		chk(rd, 48'h0);
		for (k = 0; k < 40; k++) begin
			wb(1'b1, DSRM_CFG_OFS, 32'($random(seed)), 4'(k + 1));
			if (k[0] == 1'b0) cfg = wb_dat_i[3:0];
			wb(1'b0, DSRM_CFG_OFS, 32'h0, 4'hF);
			chk(rd, 48'(cfg));
			repeat (5) run_cmd(1'b0);
			run_cmd(1'b1);
		end
		hold_ack <= 1'b1;
		run_cmd(1'b0);
		{clk_en, core_reset} <= 2'h1;
		repeat (3) @(posedge clock);
		chk({data_access_request, request_abort}, 2'h2);
		clk_en <= 1'b1;
		repeat (2) @(posedge clock);
		chk({data_access_request, request_abort}, 2'h3);
		@(posedge clock);
		chk({data_access_request, request_abort}, 2'h0);
		repeat (6) @(posedge clock);
		chk(data_access_request, 1'b0);
		{core_reset, hold_ack} <= 2'h0;
		@(posedge clock);
		run_cmd(1'b0);
		repeat (40) @(posedge clock);
		chk(exp_q.size(), 48'h0);
		tally_and_finish();
	end
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule : data_side_bus_request_master_tb_top
`default_nettype wire

// ===== dsrm_pkg.sv
/*
 * dsrm_pkg: constants and types shared by the data-side bus request master.
 * Assumes a 32-bit classic Wishbone register port and one 100 MHz clock.
 */
`default_nettype none

package dsrm_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] DSRM_CFG_OFS  = 8'h00;
	localparam logic [7:0] DSRM_STAT_OFS = 8'h04;

	// ----------------------------------------------------------------
	// config fields
	// ----------------------------------------------------------------
	localparam int DSRM_CFG_LWL_BIT  = 0;
	localparam int DSRM_CFG_LOAD_NO_ALLOCATE_BIT = 1;
	localparam int DSRM_CFG_STORE_NO_ALLOCATE_BIT = 2;
	localparam int DSRM_CFG_PRIO_BIT = 3;
	localparam logic [3:0] DSRM_CFG_RST = 4'h0;

	// ----------------------------------------------------------------
	// status fields
	// ----------------------------------------------------------------
	localparam int DSRM_ST_REQ_BIT   = 0;
	localparam int DSRM_ST_ABORT_BIT = 1;
	localparam int DSRM_ST_HALT_BIT  = 2;
	localparam int DSRM_ST_RDCNT_LSB = 3;
	localparam int DSRM_ST_WRBSY_BIT = 5;
	localparam int DSRM_ST_GAP_LSB   = 6;

	// ----------------------------------------------------------------
	// timing and limits
	// ----------------------------------------------------------------
	localparam int         DSRM_MAX_READS  = 2;
	localparam logic [1:0] DSRM_WR_GAP_CYC = 2'h2;
	localparam logic [2:0] DSRM_WORD_BYTES = 3'h4;

	typedef enum logic [2:0] {
		DSRM_IDLE  = 3'b001,
		DSRM_REQ   = 3'b010,
		DSRM_ABORT = 3'b100
	} dsrm_state_type;

endpackage : dsrm_pkg

`default_nettype wire

// ===== dsrm_request_master.sv
/*
 * dsrm_request_master: request side of the data-cache bus master port.
 * Assumes slave and arbiter run on this clock; core commands and
 * completion strobes are synchronous; registers over classic Wishbone.
 */
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module dsrm_request_master
	import dsrm_pkg::*;
#(
	parameter int MAX_READS = DSRM_MAX_READS
) (
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// core command port
	input  wire logic        cmd_valid,
	input  wire logic        cmd_read,
	input  wire logic [0:31] cmd_addr,
	input  wire logic [2:0]  cmd_nbytes,
	input  wire logic        cmd_cacheable,
	input  wire logic        cmd_write_thru,
	input  wire logic        cmd_user_attr,
	input  wire logic        cmd_guarded,
	input  wire logic        cmd_touch,
	input  wire logic        cmd_line_write,
	input  wire logic        cmd_hit,
	input  wire logic        cmd_stall,
	input  wire logic        core_reset,
	output logic             cmd_rd_ready,
	output logic             cmd_wr_ready,
	output logic             cmd_taken,
	// bus request outputs
	output logic             data_access_request,
	output logic             read_not_write,
	output logic      [0:31] request_address,
	output logic             line_size_select,
	output logic             cacheable_attr,
	output logic             write_through_attr,
	output logic             user_defined_attr,
	output logic             guarded_attr,
	output logic      [0:7]  byte_lane_enables,
	output logic      [0:1]  request_priority,
	output logic             request_abort,
	// bus completion inputs
	input  wire logic        slave_address_ack,
	input  wire logic        write_data_ack,
	input  wire logic        write_data_last,
	input  wire logic        read_complete
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// the read counter is two bits wide and never passes MAX_READS, as ready holds reads off there
	if (MAX_READS < 1 || MAX_READS > 2) begin : g_bad_max_reads
		$error("MAX_READS must be 1 or 2");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dsrm_state_type state_ff;
	dsrm_state_type nxt_state;
	logic [3:0]     cfg_ff;
	logic [1:0]     rd_cnt_ff;
	logic [1:0]     nxt_rd_cnt;
	logic           wr_busy_ff;
	logic           nxt_wr_busy;
	logic [1:0]     gap_ff;
	logic [1:0]     nxt_gap;
	logic           halt_ff;
	logic           nxt_halt;
	logic           req_ff;
	logic           abort_ff;
	logic           rnw_ff;
	logic           line_ff;
	logic           cach_ff;
	logic           wt_ff;
	logic           user_ff;
	logic           guard_ff;
	logic [0:31]    addr_ff;
	logic [0:7]     be_ff;
	logic [0:1]     prio_ff;
	logic           rd_rdy_ff;
	logic           wr_rdy_ff;
	logic           taken_ff;
	logic           ack_ff;
	logic [31:0]    rdata_ff;

	// ----------------------------------------------------------------
	// transfer decision
	// ----------------------------------------------------------------
	wire cfg_lwl  = cfg_ff[DSRM_CFG_LWL_BIT];
	wire cfg_load_no_allocate = cfg_ff[DSRM_CFG_LOAD_NO_ALLOCATE_BIT];
	wire cfg_store_no_allocate = cfg_ff[DSRM_CFG_STORE_NO_ALLOCATE_BIT];
	wire cfg_prio = cfg_ff[DSRM_CFG_PRIO_BIT];

	// touch prefetches ignore the no-allocate bits
	wire alloc_ld = cmd_touch | ~cfg_load_no_allocate;
	wire alloc_st = cmd_touch | ~cfg_store_no_allocate;
	// a store hit already owns its line and never allocates
	wire st_alloc = ~cmd_read & ~cmd_line_write & ~cmd_hit & cmd_cacheable
		& alloc_st;

	// an allocating store fetches the line first
	wire bus_rnw = cmd_read | st_alloc;
	wire line_req = cmd_line_write | st_alloc
		| (cmd_read & (cmd_cacheable ? alloc_ld : cfg_lwl));
	// write-back store hits are absorbed by the cache
	wire no_bus = ~cmd_read & ~cmd_line_write & cmd_cacheable
		& ~cmd_write_thru & cmd_hit & ~st_alloc;

	// ----------------------------------------------------------------
	// command acceptance
	// ----------------------------------------------------------------
	wire is_idle = (state_ff == DSRM_IDLE);
	wire slot_ok = no_bus ? 1'b1 : (bus_rnw ? rd_rdy_ff : wr_rdy_ff);
	wire accept  = clk_en & cmd_valid & is_idle & ~halt_ff & slot_ok
		& ~core_reset;
	wire issue   = accept & ~no_bus;

	// ----------------------------------------------------------------
	// byte enables
	// ----------------------------------------------------------------
	wire [1:0] boff   = cmd_addr[30:31];
	wire [2:0] span   = DSRM_WORD_BYTES - {1'b0, boff};
	wire [2:0] n_req  = (cmd_nbytes == 3'h0) ? 3'h1
		: ((cmd_nbytes > DSRM_WORD_BYTES) ? DSRM_WORD_BYTES : cmd_nbytes);
	// clipping at the word end keeps every pattern inside one word
	wire [2:0] n_eff  = (n_req > span) ? span : n_req;
	wire [2:0] last_b = 3'({1'b0, boff} + n_eff - 3'h1);
	logic [0:7] be_calc;

	// address bit 29 picks which half of the lanes a word uses
	genvar gl;
	generate
		for (gl = 0; gl < 8; gl++) begin : g_lane
			localparam logic       LANE_W = (gl >= 4);
			localparam logic [2:0] LANE_B = 3'(gl % 4);
			assign be_calc[gl] = ~line_req
				& (cmd_addr[29] == LANE_W)
				& (LANE_B >= {1'b0, boff})
				& (LANE_B <= last_b);
		end
	endgenerate

	// line requests carry only the line-aligned part
	wire [0:31] addr_calc = line_req ? {cmd_addr[0:26], 5'h00}
		: cmd_addr;
	wire [0:1] prio_calc = {cfg_prio, bus_rnw | cmd_stall};

	// ----------------------------------------------------------------
	// request sequencing
	// ----------------------------------------------------------------
	// an ack outside a request is not ours and is ignored
	wire acked   = (state_ff == DSRM_REQ) & slave_address_ack;
	// completion counts whole reads, so beat order never matters
	wire rd_done = read_complete & (rd_cnt_ff != 2'h0);
	wire wr_done = write_data_ack & write_data_last & wr_busy_ff;

	always_comb begin
		nxt_state = state_ff;
		// halt keeps new requests off until core reset ends
		nxt_halt  = halt_ff & core_reset;
		case (state_ff)
			DSRM_IDLE: begin
				if (core_reset)
					nxt_halt = 1'b1;
				else if (issue)
					nxt_state = DSRM_REQ;
			end
			DSRM_REQ: begin
				if (core_reset)
					nxt_state = DSRM_ABORT;
				else if (slave_address_ack)
					nxt_state = DSRM_IDLE;
			end
			DSRM_ABORT: begin
				nxt_state = DSRM_IDLE;
				nxt_halt  = 1'b1;
			end
			default: nxt_state = DSRM_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// outstanding request tracking
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rd_cnt  = rd_cnt_ff;
		nxt_wr_busy = wr_busy_ff;
		nxt_gap     = (gap_ff != 2'h0) ? gap_ff - 2'h1 : 2'h0;
		if (acked & ~core_reset & rnw_ff)
			nxt_rd_cnt = nxt_rd_cnt + 2'h1;
		if (rd_done)
			nxt_rd_cnt = nxt_rd_cnt - 2'h1;
		if (acked & ~core_reset & ~rnw_ff)
			nxt_wr_busy = 1'b1;
		if (wr_done) begin
			nxt_wr_busy = 1'b0;
			nxt_gap     = DSRM_WR_GAP_CYC;
		end
	end

	// ----------------------------------------------------------------
	// ready flags
	// ----------------------------------------------------------------
	// ready looks one cycle ahead so it can come from a flop
	wire nxt_free = (nxt_state == DSRM_IDLE) & ~nxt_halt & ~issue;
	wire nxt_rd_rdy = nxt_free & (nxt_rd_cnt < 2'(MAX_READS));
	wire nxt_wr_rdy = nxt_free & ~nxt_wr_busy & (nxt_gap == 2'h0)
		& ~(wr_done);

	// clk_en low freezes every flop, the bus ack included
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_ff   <= DSRM_IDLE;
			rd_cnt_ff  <= 2'h0;
			wr_busy_ff <= 1'b0;
			gap_ff     <= 2'h0;
			halt_ff    <= 1'b0;
			rd_rdy_ff  <= 1'b0;
			wr_rdy_ff  <= 1'b0;
			taken_ff   <= 1'b0;
		end else if (clk_en) begin
			state_ff   <= nxt_state;
			rd_cnt_ff  <= nxt_rd_cnt;
			wr_busy_ff <= nxt_wr_busy;
			gap_ff     <= nxt_gap;
			halt_ff    <= nxt_halt;
			rd_rdy_ff  <= nxt_rd_rdy;
			wr_rdy_ff  <= nxt_wr_rdy;
			taken_ff   <= accept;
		end
	end

	// request line and abort marker
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			req_ff   <= 1'b0;
			abort_ff <= 1'b0;
		end else if (clk_en) begin
			req_ff   <= (nxt_state == DSRM_REQ)
				| (nxt_state == DSRM_ABORT);
			abort_ff <= (nxt_state == DSRM_ABORT);
		end
	end

	// qualifiers load only on issue and then stand untouched
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rnw_ff   <= 1'b0;
			line_ff  <= 1'b0;
			cach_ff  <= 1'b0;
			wt_ff    <= 1'b0;
			user_ff  <= 1'b0;
			guard_ff <= 1'b0;
			addr_ff  <= 32'h00000000;
			be_ff    <= 8'h00;
			prio_ff  <= 2'h0;
		end else if (issue) begin
			rnw_ff   <= bus_rnw;
			line_ff  <= line_req;
			cach_ff  <= cmd_cacheable;
			wt_ff    <= cmd_write_thru & cmd_cacheable;
			user_ff  <= cmd_user_attr;
			guard_ff <= cmd_guarded;
			addr_ff  <= addr_calc;
			be_ff    <= be_calc;
			prio_ff  <= prio_calc;
		end
	end

	// ----------------------------------------------------------------
	// wishbone registers
	// ----------------------------------------------------------------
	wire wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire hit_cfg  = (wb_adr_i == DSRM_CFG_OFS);
	wire hit_stat = (wb_adr_i == DSRM_STAT_OFS);
	// config lands on the request edge, the same edge that raises ack
	wire cfg_wr   = clk_en & wb_req & wb_we_i & hit_cfg & wb_sel_i[0];

	// status is read only; writes there are acked and dropped
	logic [31:0] stat_word;
	always_comb begin
		stat_word = 32'h00000000;
		stat_word[DSRM_ST_REQ_BIT]   = req_ff;
		stat_word[DSRM_ST_ABORT_BIT] = abort_ff;
		stat_word[DSRM_ST_HALT_BIT]  = halt_ff;
		stat_word[DSRM_ST_RDCNT_LSB +: 2] = rd_cnt_ff;
		stat_word[DSRM_ST_WRBSY_BIT] = wr_busy_ff;
		stat_word[DSRM_ST_GAP_LSB +: 2]   = gap_ff;
	end

	// unmapped offsets still ack and read as zero
	wire [31:0] rd_mux = hit_cfg ? {28'h0000000, cfg_ff}
		: (hit_stat ? stat_word : 32'h00000000);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ff   <= DSRM_CFG_RST;
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else if (clk_en) begin
			ack_ff   <= wb_req;
			rdata_ff <= wb_req ? rd_mux : 32'h00000000;
			if (cfg_wr)
				cfg_ff <= wb_dat_i[3:0];
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o            = ack_ff;
	assign wb_dat_o            = rdata_ff;
	assign cmd_rd_ready        = rd_rdy_ff;
	assign cmd_wr_ready        = wr_rdy_ff;
	assign cmd_taken           = taken_ff;
	assign data_access_request = req_ff;
	assign request_abort       = abort_ff;
	assign read_not_write      = rnw_ff;
	assign request_address     = addr_ff;
	assign line_size_select    = line_ff;
	assign cacheable_attr      = cach_ff;
	assign write_through_attr  = wt_ff;
	assign user_defined_attr   = user_ff;
	assign guarded_attr        = guard_ff;
	assign byte_lane_enables   = be_ff;
	assign request_priority    = prio_ff;

endmodule : dsrm_request_master

`default_nettype wire

// ===== dsrm_request_master_assertions.sv
/* Request-port assertions for dsrm_request_master.
   Sees only the block's ports; attached by the bind at the foot. */
`timescale 1ns/1ns
`default_nettype none
module dsrm_request_master_assertions #(parameter int MAX_READS = 2) (
	input wire logic clock, rst_b, clk_en, core_reset, request_abort,
	input wire logic data_access_request, read_not_write,
	input wire logic line_size_select, cacheable_attr, write_through_attr,
	input wire logic user_defined_attr, guarded_attr,
	input wire logic [0:31] request_address,
	input wire logic [0:7]  byte_lane_enables,
	input wire logic [0:1]  request_priority,
	input wire logic slave_address_ack, write_data_ack,
	input wire logic write_data_last, read_complete
);
	wire        req  = data_access_request;
	wire        acc  = req && slave_address_ack && clk_en;
	wire        wend = write_data_ack && write_data_last;
	wire [3:0]  nib  = byte_lane_enables[0:3] | byte_lane_enables[4:7];
	wire [47:0] qual = {read_not_write, line_size_select, cacheable_attr,
		write_through_attr, user_defined_attr, guarded_attr,
		request_priority, byte_lane_enables, request_address};
	logic [2:0] rd_cnt_ff;
	logic       wr_bsy_ff;
	// reads counted from ack to completion, write from ack to last beat
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_cnt_ff <= 3'h0;
			wr_bsy_ff <= 1'b0;
		end else begin
			rd_cnt_ff <= rd_cnt_ff + 3'(acc && read_not_write)
				- 3'(read_complete);
			wr_bsy_ff <= (wr_bsy_ff || (acc && !read_not_write)) && !wend;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	AST_REQ_DROP: assert property (acc |=> !req)
		else $error("request held after address ack");
	AST_QUAL_HOLD: assert property (req |=> $stable(qual))
		else $error("qualifier moved");
	AST_LINE_FMT: assert property (
		req && line_size_select |-> byte_lane_enables == 8'h00
		&& request_address[27:31] == 5'h00) else $error("line format");
	AST_WORD_BE: assert property (
		req && !line_size_select |-> (nib inside {4'h8, 4'hC, 4'hE, 4'hF,
		4'h4, 4'h6, 4'h7, 4'h2, 4'h3, 4'h1}) && (request_address[29] ?
		byte_lane_enables[0:3] == 4'h0 : byte_lane_enables[4:7] == 4'h0))
		else $error("byte enables invalid");
	AST_RD_PRIO: assert property (req && read_not_write |->
		request_priority[1]) else $error("read priority low");
	AST_RD_LIMIT: assert property (req && read_not_write |->
		rd_cnt_ff < MAX_READS) else $error("too many reads");
	AST_WR_GAP: assert property (req && !read_not_write |->
		!wr_bsy_ff && !$past(wend)) else $error("write too early");
	AST_ABORT: assert property (request_abort |->
		req ##1 !req && !request_abort) else $error("abort shape");
	AST_ABORT_ON_RST: assert property (clk_en && core_reset && req
		&& !request_abort && !slave_address_ack |=> req && request_abort)
		else $error("no abort on core reset");
	AST_RST_QUIET: assert property (core_reset && !req |=> !req)
		else $error("request during core reset");
	AST_WT_UNCACHED: assert property (req && !cacheable_attr |->
		!write_through_attr) else $error("write-through uncached");
	AST_RESET_LOW: assert property (@(posedge clock) disable iff (1'b0)
		!rst_b |-> !req && !request_abort) else $error("active in reset");
endmodule : dsrm_request_master_assertions
bind dsrm_request_master dsrm_request_master_assertions
	#(.MAX_READS(MAX_READS)) i_chk (
	.clock(clock),
	.rst_b(rst_b),
	.clk_en(clk_en),
	.core_reset(core_reset),
	.request_abort(request_abort),
	.data_access_request(data_access_request),
	.read_not_write(read_not_write),
	.line_size_select(line_size_select),
	.cacheable_attr(cacheable_attr),
	.write_through_attr(write_through_attr),
	.user_defined_attr(user_defined_attr),
	.guarded_attr(guarded_attr),
	.request_address(request_address),
	.byte_lane_enables(byte_lane_enables),
	.request_priority(request_priority),
	.slave_address_ack(slave_address_ack),
	.write_data_ack(write_data_ack),
	.write_data_last(write_data_last),
	.read_complete(read_complete)
);
`default_nettype wire

// ===== dsrm_slave_model.sv
/* Slave and arbiter model: random address-ack delay, data phases
   served one request at a time. Runs on the bench clock. */
`timescale 1ns/1ns
`default_nettype none
module dsrm_slave_model #(parameter int LINE_BEATS = 4) (
	input wire logic clock, rst_b, hold_ack,
	input wire logic data_access_request, read_not_write,
	input wire logic line_size_select, request_abort,
	output logic slave_address_ack, write_data_ack,
	output logic write_data_last, read_complete
);
	logic [2:0] wait_ff, dly_ff;
	logic [1:0] q[$];
	logic [1:0] h;
	int         n;
	integer     seed = 32'h8DD6;
	// ack can land in the very cycle the request first shows
	assign slave_address_ack = data_access_request && !request_abort
		&& !hold_ack && wait_ff >= dly_ff;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_ff <= 3'h0;
			dly_ff <= 3'h0;
			q.delete();
		end else begin
			wait_ff <= data_access_request ? wait_ff + 3'h1 : 3'h0;
			if (!data_access_request)
				dly_ff <= 3'($random(seed)) & 3'h3;
			if (slave_address_ack)
				q.push_back({read_not_write, line_size_select});
		end
	end
	// oldest request first, all its data before the next one's
	initial begin
		{write_data_ack, write_data_last, read_complete} = 3'h0;
		forever begin
			@(posedge clock);
			if (q.size() != 0) begin
				h = q.pop_front();
				n = h[0] ? LINE_BEATS : 1;
				repeat (1 + 2 * dly_ff) @(posedge clock);
				for (int i = 1; i <= n; i++) begin
					write_data_ack <= !h[1];
					write_data_last <= !h[1] && i == n;
					@(posedge clock);
				end
				{write_data_ack, write_data_last} <= 2'h0;
				read_complete <= h[1];
				@(posedge clock);
				read_complete <= 1'b0;
			end
		end
	end
endmodule : dsrm_slave_model
`default_nettype wire
